// >>> swx_defs.svh
`ifndef SWX_DEFS_SVH
`define SWX_DEFS_SVH

// Register offsets
`define SWX_OFF_FEATURE 5'h01
`define SWX_OFF_COUNT 5'h02
`define SWX_OFF_LBA_LOW 5'h03
`define SWX_OFF_LBA_MID 5'h04
`define SWX_OFF_LBA_HIGH 5'h05
`define SWX_OFF_DEVSEL 5'h06
`define SWX_OFF_COMMAND 5'h07
`define SWX_OFF_DEVCTL 5'h08
`define SWX_OFF_IRQ_STAT 5'h09
`define SWX_OFF_IRQ_MASK 5'h0a
`define SWX_OFF_DEF_LIMIT 5'h10
`define SWX_OFF_DEF_LAST 5'h17

// Command code
`define SWX_OP_WRITE_STREAM 8'h3b

// Feature option bits
`define SWX_FEAT_PRIO 7
`define SWX_FEAT_KEEP 6
`define SWX_FEAT_COMMIT 5
`define SWX_FEAT_RESUME 4

// Condition bits
`define SWX_ST_BUSY 7
`define SWX_ST_READY 6
`define SWX_ST_STREAM_ERR 5
`define SWX_ST_DRQ 3
`define SWX_ST_ERR 0

// Error flag bits
`define SWX_ERR_NOT_FOUND 4
`define SWX_ERR_ABORT 2
`define SWX_ERR_TLIM 0

// Upper byte select in device control
`define SWX_DEVCTL_UPPER 7

// Reset values
`define SWX_RST_BYTE 8'h00
`define SWX_RST_DEVSEL 8'h00
`define SWX_RST_MASK 3'h0

// Counts and timing
`define SWX_MAX_SECTORS 17'h10000
`define SWX_CLK_PERIOD_NS 100
`define SWX_US_NS 1000
`define SWX_CYC_PER_US \
  ((`SWX_US_NS + `SWX_CLK_PERIOD_NS - 1) / `SWX_CLK_PERIOD_NS)

`endif

// >>> swx_pkg.sv
package swx_pkg;

  typedef enum logic [1:0] {
    SWX_IDLE,
    SWX_XFER,
    SWX_FLUSH,
    SWX_END
  } swx_state_e;

  typedef logic [47:0] swx_lba_t;
  typedef logic [23:0] swx_us_t;

endpackage

// >>> swx_timer_if.sv
`timescale 1ns/1ps

interface swx_timer_if;
  logic load;
  logic [23:0] limit_us;
  logic stop;
  logic expired;
  logic running;

  modport ctrl (output load, output limit_us, output stop,
    input expired, input running);
  modport tmr (input load, input limit_us, input stop,
    output expired, output running);
endinterface

// >>> swx_limit_timer.sv
`timescale 1ns/1ps

module swx_limit_timer
  import swx_pkg::*;
#(
  parameter int CYC_PER_US = 10,
  parameter swx_us_t MIN_LIMIT_US = 24'h000010
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control side
  swx_timer_if.tmr tif
);
  localparam int PW = (CYC_PER_US > 1) ? $clog2(CYC_PER_US) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_US - 1);

  logic [PW-1:0] pre;
  swx_us_t left;

  wire swx_us_t clamped = (tif.limit_us < MIN_LIMIT_US) ?
    MIN_LIMIT_US : tif.limit_us; // [R15]
  wire tick = tif.running && (pre == PRE_LAST);
  wire last = tick && (left == 24'h000001);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= '0;
      left <= '0;
      tif.running <= 1'b0;
      tif.expired <= 1'b0;
    end else begin
      tif.expired <= 1'b0;
      if (tif.load) begin
        pre <= '0;
        left <= clamped; // [R15]
        tif.running <= 1'b1;
      end else if (tif.stop) begin
        pre <= '0;
        tif.running <= 1'b0;
      end else if (tick) begin
        pre <= '0;
        left <= left - 24'h000001;
        if (last) begin
          tif.running <= 1'b0;
          tif.expired <= 1'b1;
        end
      end else if (tif.running) begin
        pre <= pre + 1'b1;
      end
    end
  end

  property p_clamp;
    @(posedge clk) disable iff (!rst_n)
    tif.load |=> left >= MIN_LIMIT_US && tif.running;
  endproperty
  a_clamp: assert property (p_clamp) // [R15]
    else $error("Loaded limit below the minimum");
endmodule // swx_limit_timer

// >>> swx_stream_write.sv
`timescale 1ns/1ps
`include "swx_defs.svh"

// What this block does
// [R1] Command code 3Bh written to the command register starts this command.
// [R2] Moves 1 to 65536 sectors; a count of zero means 65536.
// [R3] Latest count write gives bits 7:0, the earlier one bits 15:8.
// [R4] Address: current bytes give 23:0, previous bytes give 47:24.
// [R5] Keep-going mode moves all data; ends stream error set, error clear.
// [R6] Keep-going mode and limit elapsed: stop, stream error, limit flag set.
// [R7] Limit flag, error bit 0, set whenever the time limit runs out.
// [R8] Priority request passed on; command must finish within the limit.
// [R9] Media commit: flush stream data before reporting completion.
// [R10] Resume: start at the stream's last reported error address.
// [R11] Feature bits 2:0 select the stream written.
// [R12] Limit in microseconds is previous feature byte times the time unit.
// [R13] Zero limit uses the stream default; zero default means no limit.
// [R14] Limit runs from the command write to the completion interrupt.
// [R15] A limit below the built-in minimum is raised to the minimum.
// [R16] Address registers return the first failing address, upper bytes too.
// [R17] In keep-going mode, tries to move all requested data within the limit.
// [R18] Without keep-going, end at the first error with error bit set.
module swx_stream_write
  import swx_pkg::*;
#(
  parameter logic [15:0] TIME_UNIT_US = 16'h0001,
  parameter swx_us_t MIN_LIMIT_US = 24'h000010
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Register port
  input wire logic [4:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Media side
  input wire logic SECTOR_DONE,
  input wire logic SECTOR_ERR,
  input wire logic ERR_IS_NOT_FOUND,
  input wire logic FLUSH_DONE,
  output logic XFER_REQ,
  output logic [47:0] XFER_LBA,
  output logic [2:0] XFER_STREAM,
  output logic XFER_URGENT,
  output logic RECOVER,
  output logic FLUSH_REQ,
  // Interrupts
  output logic HOST_INT_REQ,
  output logic IRQ
);
  logic rst_q1;
  logic rst_n;
  swx_state_e state;
  swx_state_e next_state;
  logic [7:0] tf_cur [5];
  logic [7:0] tf_prev [5];
  logic [7:0] tf_view [5];
  logic [7:0] def_limit [8];
  swx_lba_t last_err [8];
  logic [7:0] devsel;
  logic [7:0] devctl;
  logic [16:0] remaining;
  swx_lba_t cur_lba;
  swx_lba_t fail_lba;
  logic bsy, keep, commit, resume, err_seen;
  logic st_err, st_strm, e_nf, e_abort, e_tlim;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;

  swx_timer_if tif ();

  // Reset release through two stages
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  swx_limit_timer #(
    .CYC_PER_US(`SWX_CYC_PER_US),
    .MIN_LIMIT_US(MIN_LIMIT_US)
  ) u_timer (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .tif(tif.tmr)
  );

  // Task-file fields
  wire [7:0] feat = tf_cur[0];
  wire [7:0] lim_byte = tf_prev[0];
  wire [15:0] cnt = {tf_prev[1], tf_cur[1]}; // [R3]
  wire swx_lba_t host_lba = {tf_prev[4], tf_prev[3], tf_prev[2],
    tf_cur[4], tf_cur[3], tf_cur[2]}; // [R4]
  wire [2:0] stream = feat[2:0]; // [R11]
  wire swx_lba_t resume_lba = last_err[stream];
  wire swx_lba_t start_lba = feat[`SWX_FEAT_RESUME] ?
    resume_lba : host_lba; // [R10]

  // Command decode
  wire cmd_wr = WR && (ADDR == `SWX_OFF_COMMAND) && (state == SWX_IDLE);
  wire start = cmd_wr && (WDATA == `SWX_OP_WRITE_STREAM); // [R1]
  wire bad_op = cmd_wr && !start;
  wire [16:0] start_count = (cnt == 16'h0000) ?
    `SWX_MAX_SECTORS : {1'b0, cnt}; // [R2]

  // Limit selection; zero in both places leaves the timer idle
  wire [7:0] eff_byte = (lim_byte != 8'h00) ?
    lim_byte : def_limit[stream]; // [R13]
  wire swx_us_t limit_us = 24'(eff_byte) * 24'(TIME_UNIT_US); // [R12]
  assign tif.load = start && (eff_byte != 8'h00); // [R13]
  assign tif.limit_us = limit_us;
  assign tif.stop = (state == SWX_END); // [R14]
  wire expire = tif.expired;

  // Transfer events
  wire sector_ev = (state == SWX_XFER) && SECTOR_DONE;
  wire last_sector = (remaining == 17'h00001);
  wire err_ev = sector_ev && SECTOR_ERR;
  wire err_stop = err_ev && !keep; // [R18]
  wire to_ev = expire && ((state == SWX_XFER) || (state == SWX_FLUSH));

  always_comb begin
    next_state = state;
    case (state)
      SWX_IDLE: begin
        if (start) begin
          next_state = SWX_XFER;
        end
      end
      SWX_XFER: begin
        if (to_ev || err_stop) begin
          next_state = SWX_END; // [R6]
        end else if (sector_ev && last_sector) begin
          next_state = commit ? SWX_FLUSH : SWX_END; // [R9]
        end
      end
      SWX_FLUSH: begin
        if (to_ev || FLUSH_DONE) begin
          next_state = SWX_END; // [R9]
        end
      end
      SWX_END: next_state = SWX_IDLE;
      default: next_state = SWX_IDLE;
    endcase
  end

  // Registered so the pin carries no gate
  wire next_recover = (next_state == SWX_XFER) &&
    (start ? feat[`SWX_FEAT_RESUME] : resume); // [R10]

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state <= SWX_IDLE;
      XFER_REQ <= 1'b0;
      FLUSH_REQ <= 1'b0;
      RECOVER <= 1'b0;
    end else begin
      state <= next_state;
      XFER_REQ <= (next_state == SWX_XFER);
      FLUSH_REQ <= (next_state == SWX_FLUSH);
      RECOVER <= next_recover; // [R10]
    end
  end

  // Task-file byte pairs: each write while not busy pushes current into previous
  genvar i;
  generate
    for (i = 0; i < 5; i++) begin : g_tf
      wire hit = WR && !bsy && (ADDR == 5'(i + 1));
      if (i >= 2) begin : g_addr
        wire load_fail = (state == SWX_END) && err_seen;
        always_ff @(posedge CLK_SYS or negedge rst_n) begin
          if (!rst_n) begin
            tf_cur[i] <= `SWX_RST_BYTE;
            tf_prev[i] <= `SWX_RST_BYTE;
          end else if (hit) begin
            tf_prev[i] <= tf_cur[i];
            tf_cur[i] <= WDATA;
          end else if (load_fail) begin
            tf_cur[i] <= fail_lba[8*(i-2) +: 8]; // [R16]
            tf_prev[i] <= fail_lba[24+8*(i-2) +: 8]; // [R16]
          end
        end
      end else begin : g_plain
        always_ff @(posedge CLK_SYS or negedge rst_n) begin
          if (!rst_n) begin
            tf_cur[i] <= `SWX_RST_BYTE;
            tf_prev[i] <= `SWX_RST_BYTE;
          end else if (hit) begin
            tf_prev[i] <= tf_cur[i];
            tf_cur[i] <= WDATA;
          end
        end
      end
      assign tf_view[i] = devctl[`SWX_DEVCTL_UPPER] ?
        tf_prev[i] : tf_cur[i]; // [R16]
    end
  endgenerate

  // Per-stream default limit and last error address
  genvar s;
  generate
    for (s = 0; s < 8; s++) begin : g_stream
      wire def_hit = WR && (ADDR == 5'(`SWX_OFF_DEF_LIMIT + s));
      wire err_hit = err_ev && !err_seen && (XFER_STREAM == 3'(s));
      always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
          def_limit[s] <= `SWX_RST_BYTE;
          last_err[s] <= '0;
        end else begin
          if (def_hit) begin
            def_limit[s] <= WDATA;
          end
          if (err_hit) begin
            last_err[s] <= cur_lba; // [R10]
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      devsel <= `SWX_RST_DEVSEL;
      devctl <= `SWX_RST_BYTE;
    end else if (WR && ADDR == `SWX_OFF_DEVSEL) begin
      devsel <= WDATA;
    end else if (WR && ADDR == `SWX_OFF_DEVCTL) begin
      devctl <= WDATA;
    end
  end

  // Command progress and ending status
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      bsy <= 1'b0;
      keep <= 1'b0;
      commit <= 1'b0;
      resume <= 1'b0;
      err_seen <= 1'b0;
      remaining <= '0;
      cur_lba <= '0;
      fail_lba <= '0;
      st_err <= 1'b0;
      st_strm <= 1'b0;
      e_nf <= 1'b0;
      e_abort <= 1'b0;
      e_tlim <= 1'b0;
      XFER_STREAM <= 3'h0;
      XFER_URGENT <= 1'b0;
    end else if (start) begin
      bsy <= 1'b1;
      keep <= feat[`SWX_FEAT_KEEP];
      commit <= feat[`SWX_FEAT_COMMIT];
      resume <= feat[`SWX_FEAT_RESUME]; // [R10]
      XFER_STREAM <= stream; // [R11]
      XFER_URGENT <= feat[`SWX_FEAT_PRIO]; // [R8]
      remaining <= start_count; // [R2]
      cur_lba <= start_lba; // [R4]
      err_seen <= 1'b0;
      fail_lba <= '0;
      st_err <= 1'b0;
      st_strm <= 1'b0;
      e_nf <= 1'b0;
      e_abort <= 1'b0;
      e_tlim <= 1'b0;
    end else if (bad_op) begin
      st_err <= 1'b1;
      st_strm <= 1'b0;
      e_abort <= 1'b1;
      e_nf <= 1'b0;
      e_tlim <= 1'b0;
    end else begin
      if (sector_ev) begin
        cur_lba <= cur_lba + 48'h000000000001;
        remaining <= remaining - 17'h00001;
      end
      if (err_ev) begin
        e_nf <= e_nf | ERR_IS_NOT_FOUND; // [R5]
        e_abort <= e_abort | !ERR_IS_NOT_FOUND;
        if (!err_seen) begin
          err_seen <= 1'b1;
          fail_lba <= cur_lba; // [R16]
        end
        if (keep) begin
          st_strm <= 1'b1; // [R5] [R17]
        end else begin
          st_err <= 1'b1; // [R18]
        end
      end
      if (to_ev) begin
        e_tlim <= 1'b1; // [R7]
        if (keep) begin
          st_strm <= 1'b1; // [R6]
        end else begin
          st_err <= 1'b1;
        end
      end
      if (state == SWX_END) begin
        bsy <= 1'b0;
      end
    end
  end

  assign XFER_LBA = cur_lba;

  // Status and interrupt
  wire status_rd = RD && (ADDR == `SWX_OFF_COMMAND);
  wire done_ev = (state == SWX_END) || bad_op;
  wire [2:0] ev = {err_ev, to_ev, done_ev};
  wire [2:0] clr = (WR && ADDR == `SWX_OFF_IRQ_STAT) ? WDATA[2:0] : 3'h0;
  wire [2:0] next_irq_stat = (irq_stat & ~clr) | ev;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      HOST_INT_REQ <= 1'b0;
      irq_stat <= 3'h0;
      irq_mask <= `SWX_RST_MASK;
      IRQ <= 1'b0;
    end else begin
      HOST_INT_REQ <= done_ev | (HOST_INT_REQ & !status_rd); // [R14]
      irq_stat <= next_irq_stat;
      if (WR && ADDR == `SWX_OFF_IRQ_MASK) begin
        irq_mask <= WDATA[2:0];
      end
      IRQ <= |(next_irq_stat & irq_mask);
    end
  end

  // Read side
  wire [7:0] err_byte = (8'(e_nf) << `SWX_ERR_NOT_FOUND) |
    (8'(e_abort) << `SWX_ERR_ABORT) | (8'(e_tlim) << `SWX_ERR_TLIM); // [R7]
  wire [7:0] cond_byte = (8'(bsy) << `SWX_ST_BUSY) |
    (8'h01 << `SWX_ST_READY) | (8'(st_strm) << `SWX_ST_STREAM_ERR) |
    (8'(XFER_REQ) << `SWX_ST_DRQ) | (8'(st_err) << `SWX_ST_ERR);
  wire in_tf = (ADDR >= `SWX_OFF_COUNT) && (ADDR <= `SWX_OFF_LBA_HIGH);
  wire in_def = (ADDR >= `SWX_OFF_DEF_LIMIT) && (ADDR <= `SWX_OFF_DEF_LAST);
  wire [2:0] tf_idx = 3'(ADDR - 5'h01);
  wire [7:0] rd_val =
    (ADDR == `SWX_OFF_FEATURE) ? err_byte :
    in_tf ? tf_view[tf_idx] :
    (ADDR == `SWX_OFF_DEVSEL) ? devsel :
    (ADDR == `SWX_OFF_COMMAND) ? cond_byte :
    (ADDR == `SWX_OFF_DEVCTL) ? devctl :
    (ADDR == `SWX_OFF_IRQ_STAT) ? {5'h00, irq_stat} :
    (ADDR == `SWX_OFF_IRQ_MASK) ? {5'h00, irq_mask} :
    in_def ? def_limit[ADDR[2:0]] : 8'h00;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? rd_val : 8'h00;
    end
  end

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  sequence s_keep_err;
    (state == SWX_XFER) && keep && err_ev && !last_sector && !expire;
  endsequence
  sequence s_ended_stream;
    !bsy && st_strm && !st_err && e_tlim && HOST_INT_REQ;
  endsequence

  property p_op;
    start |=> (state == SWX_XFER) && bsy && XFER_REQ;
  endproperty
  a_op: assert property (p_op) // [R1]
    else $error("Command code did not start the transfer");

  property p_zero;
    start && (cnt == 16'h0000) |=> remaining == `SWX_MAX_SECTORS;
  endproperty
  a_zero: assert property (p_zero) // [R2]
    else $error("Zero count not taken as 65536");

  property p_count;
    start && (cnt != 16'h0000) |=> remaining == {1'b0, $past(cnt)};
  endproperty
  a_count: assert property (p_count) // [R3]
    else $error("Sector count assembled wrongly");

  property p_lba;
    start && !feat[`SWX_FEAT_RESUME] |=> XFER_LBA == $past(host_lba);
  endproperty
  a_lba: assert property (p_lba) // [R4]
    else $error("Start address assembled wrongly");

  property p_resume;
    start && feat[`SWX_FEAT_RESUME] |=> XFER_LBA == $past(resume_lba);
  endproperty
  a_resume: assert property (p_resume) // [R10]
    else $error("Resume did not start at last error");

  property p_keep;
    s_keep_err |=> (state == SWX_XFER) && st_strm && !st_err;
  endproperty
  a_keep: assert property (p_keep) // [R5]
    else $error("Keep-going mode halted on error");

  property p_keep_to;
    (state == SWX_XFER) && keep && expire |=>
      (state == SWX_END) ##1 s_ended_stream;
  endproperty
  a_keep_to: assert property (p_keep_to) // [R6]
    else $error("Limit expiry ending status wrong");

  property p_tlim;
    to_ev |=> e_tlim && err_byte[`SWX_ERR_TLIM];
  endproperty
  a_tlim: assert property (p_tlim) // [R7]
    else $error("Limit flag not set on expiry");

  property p_flush;
    (state == SWX_FLUSH) && !FLUSH_DONE && !expire |=>
      (state == SWX_FLUSH) && FLUSH_REQ && bsy;
  endproperty
  a_flush: assert property (p_flush) // [R9]
    else $error("Completion before flush finished");

  property p_no_limit;
    start && (eff_byte == 8'h00) |=> !tif.running;
  endproperty
  a_no_limit: assert property (p_no_limit) // [R13]
    else $error("Timer started with no limit");

  property p_limit;
    start && (lim_byte != 8'h00) |=> tif.running;
  endproperty
  a_limit: assert property (p_limit) // [R12]
    else $error("Timer not started for programmed limit");

  property p_end;
    (state == SWX_END) |=> HOST_INT_REQ && !tif.running && !bsy;
  endproperty
  a_end: assert property (p_end) // [R14]
    else $error("Completion did not stop the limit");

  property p_stop;
    err_stop && !expire |=> (state == SWX_END) && st_err && !st_strm
      ##1 (tf_cur[2] == fail_lba[7:0]) && (tf_prev[4] == fail_lba[47:40]);
  endproperty
  a_stop: assert property (p_stop) // [R18]
    else $error("First error did not end the command");
endmodule // swx_stream_write

// >>> swx_media_model.sv
`timescale 1ns/1ps

module swx_media_model (
  // Clock
  input wire logic clk,
  // Requests from the block
  input wire logic xfer_req,
  input wire logic flush_req,
  // Bench control
  input wire logic slow,
  input wire logic not_found,
  input wire logic signed [31:0] err_at,
  // Answers to the block
  output logic sector_done,
  output logic sector_err,
  output logic err_kind,
  output logic flush_done,
  // Counts
  output int taken,
  output int flushes
);
  int fwait = 0;
  logic took;

  // A sector counts only when the block still asks for it
  assign took = xfer_req && sector_done;

  initial begin
    sector_done = 1'b0;
    sector_err = 1'b0;
    err_kind = 1'b0;
    flush_done = 1'b0;
    taken = 0;
    flushes = 0;
  end

  // Full rate when fast; a stalled medium never answers
  always @(posedge clk) begin
    if (took)
      taken <= taken + 1;
    sector_done <= xfer_req && !slow;
    sector_err <= (taken + int'(took)) == err_at;
    err_kind <= not_found;
    fwait <= flush_req ? fwait + 1 : 0;
    flush_done <= flush_req && fwait == 5;
    if (flush_req && flush_done)
      flushes <= flushes + 1;
  end
endmodule // swx_media_model

// >>> swx_stream_write_tb.sv
`timescale 1ns/1ps

module swx_stream_write_tb;
  import swx_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slow = 1'b0;
  logic not_found = 1'b0;
  int err_at = -1;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'habe9;
  int taken, flushes;
  logic [7:0] rdata, d;
  logic sector_done, sector_err, err_kind, flush_done;
  logic xfer_req, recover, flush_req, xfer_urgent, host_irq, irq;
  logic [47:0] xfer_lba;
  logic [2:0] xfer_stream;
  swx_lba_t last_err [8];

  // Small limits keep expiry runs short
  swx_stream_write #(
    .TIME_UNIT_US(16'h0001),
    .MIN_LIMIT_US(24'h000002)
  ) u_swx_stream_write (
    .CLK_SYS(clk_sys), .RST_N(rst_n),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .SECTOR_DONE(sector_done), .SECTOR_ERR(sector_err),
    .ERR_IS_NOT_FOUND(err_kind), .FLUSH_DONE(flush_done),
    .XFER_REQ(xfer_req), .XFER_LBA(xfer_lba),
    .XFER_STREAM(xfer_stream), .XFER_URGENT(xfer_urgent),
    .RECOVER(recover), .FLUSH_REQ(flush_req),
    .HOST_INT_REQ(host_irq), .IRQ(irq)
  );

  swx_media_model u_swx_media_model (
    .clk(clk_sys), .xfer_req(xfer_req), .flush_req(flush_req),
    .slow(slow), .not_found(not_found), .err_at(err_at),
    .sector_done(sector_done), .sector_err(sector_err),
    .err_kind(err_kind), .flush_done(flush_done),
    .taken(taken), .flushes(flushes)
  );

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task give_verdict;
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // The longest command moves 65536 sectors
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wr_reg(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [4:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(posedge clk_sys);
    v = rdata;
  endtask

  task wait_done(output int c);
    c = 0;
    while (host_irq !== 1'b1 && c < 70000) begin
      @(negedge clk_sys);
      c++;
    end
  endtask

  function swx_lba_t rnd48();
    return swx_lba_t'({$random(seed), $random(seed)});
  endfunction

  function automatic logic [7:0] exp_cond(input bit keep, input bit bad);
    return 8'h40 | (bad ? (keep ? 8'h20 : 8'h01) : 8'h00);
  endfunction

  // One command: program, start, wait, then check ending state
  task automatic go(input logic [7:0] lim, opt, input logic [15:0] cnt,
    input swx_lba_t lba, input int ea, input bit nf, sl, input int tl);
    int n0, f0, c, want;
    bit er;
    swx_lba_t st;
    n0 = taken;
    f0 = flushes;
    want = (cnt == 16'h0000) ? 65536 : int'(cnt);
    er = !sl && ea >= 0 && ea < want;
    st = opt[4] ? last_err[opt[2:0]] : lba;
    wr_reg(5'h01, lim);
    wr_reg(5'h01, opt);
    wr_reg(5'h02, cnt[15:8]);
    wr_reg(5'h02, cnt[7:0]);
    for (int i = 0; i < 3; i++) begin
      wr_reg(5'(3 + i), lba[24 + 8*i +: 8]);
      wr_reg(5'(3 + i), lba[8*i +: 8]);
    end
    slow <= sl;
    not_found <= nf;
    err_at <= er ? n0 + ea : -1;
    wr_reg(5'h07, 8'h3b);
    @(negedge clk_sys);
    chk(xfer_req, 1'b1);
    chk(xfer_lba, st);
    chk(xfer_stream, opt[2:0]);
    chk(xfer_urgent, opt[7]);
    chk(recover, opt[4]);
    wait_done(c);
    chk(host_irq, 1'b1);
    // An error stop ends at once, with no flush
    chk(flushes - f0, opt[5] && !(er && !opt[6]));
    if (tl > 0)
      chk(c >= tl*10 - 2 && c <= tl*10 + 8, 1'b1);
    chk(taken - n0, sl ? 0 : (er && !opt[6]) ? ea + 1 : want);
    rd_reg(5'h07, d);
    chk(d, exp_cond(opt[6], er || sl));
    rd_reg(5'h01, d);
    chk(d, {3'h0, er && nf, 1'b0, er && !nf, 1'b0, sl});
    if (er) begin
      last_err[opt[2:0]] = st + ea;
      for (int h = 0; h < 2; h++) begin
        wr_reg(5'h08, h ? 8'h80 : 8'h00);
        for (int i = 0; i < 3; i++) begin
          rd_reg(5'(3 + i), d);
          chk(d, last_err[opt[2:0]][24*h + 8*i +: 8]);
        end
      end
      wr_reg(5'h08, 8'h00);
    end
  endtask

  initial begin
    logic [7:0] o;
    logic [15:0] n;
    int e, c;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd_reg(5'h01, d);
    chk(d, 8'h00);
    rd_reg(5'h07, d);
    chk(d, 8'h40);
    rd_reg(5'h0a, d);
    chk(d, 8'h00);
    rd_reg(5'h1f, d);
    chk(d, 8'h00);
    go(8'h00, 8'h03, 16'h0100, rnd48(), -1, 1'b0, 1'b0, 0);
    go(8'h00, 8'h00, 16'h0000, rnd48(), -1, 1'b0, 1'b0, 0);
    go(8'h00, 8'h01, 16'h0008, rnd48(), 3, 1'b1, 1'b0, 0);
    go(8'h00, 8'h11, 16'h0004, rnd48(), -1, 1'b0, 1'b0, 0);
    go(8'h00, 8'h42, 16'h0008, rnd48(), 0, 1'b0, 1'b0, 0);
    go(8'h03, 8'hc3, 16'h0008, rnd48(), -1, 1'b0, 1'b1, 3);
    go(8'h01, 8'h04, 16'h0008, rnd48(), -1, 1'b0, 1'b1, 2);
    wr_reg(5'h15, 8'h02);
    go(8'h00, 8'h45, 16'h0008, rnd48(), -1, 1'b0, 1'b1, 2);
    go(8'h00, 8'h26, 16'h0004, rnd48(), -1, 1'b0, 1'b0, 0);
    // Streams 0..3 only: stream 5 now has a default limit
    for (int k = 0; k < 4; k++) begin
      o = 8'($random(seed));
      n = 16'd1 + 16'($unsigned($random(seed)) % 16);
      e = $unsigned($random(seed)) % 24;
      go(8'h00, o & 8'he3, n, rnd48(), e, o[3], 1'b0, 0);
    end
    // Unknown opcode is refused with an abort
    wr_reg(5'h07, 8'h3a);
    wait_done(c);
    chk(host_irq, 1'b1);
    rd_reg(5'h07, d);
    chk(d, 8'h41);
    rd_reg(5'h01, d);
    chk(d, 8'h04);
    // Sticky done bit, masked then unmasked, then cleared
    wr_reg(5'h09, 8'h07);
    go(8'h00, 8'h06, 16'h0002, rnd48(), -1, 1'b0, 1'b0, 0);
    chk(irq, 1'b0);
    rd_reg(5'h09, d);
    chk(d[0], 1'b1);
    wr_reg(5'h0a, 8'h01);
    repeat (2) @(negedge clk_sys);
    chk(irq, 1'b1);
    wr_reg(5'h09, 8'h01);
    repeat (2) @(negedge clk_sys);
    chk(irq, 1'b0);
    give_verdict();
  end
endmodule // swx_stream_write_tb
